// [inc/fdbm_pkg.sv]
/*
  Shared constants, carriers and coding functions of the flash disk block manager.
  Assumes one 100 MHz clock and a flash array reached through a request/acknowledge port.
*/
package fdbm_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned PRESENCE_US    = 1000;
  localparam int unsigned PRESENCE_CYC   = (PRESENCE_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W        = 20;

  // ------------------------------------------------------------
  // Geometry: pool blocks rotate, spares sit above them
  // ------------------------------------------------------------
  localparam int unsigned NLOG           = 8;
  localparam int unsigned NPOOL          = 12;
  localparam int unsigned NSPARE         = 4;
  localparam logic [3:0]  SPARE_BASE     = 4'hc;
  localparam logic [2:0]  SPARE_ALL_USED = 3'h4;

  // ------------------------------------------------------------
  // Host port map (chip select 0 space)
  // ------------------------------------------------------------
  localparam logic [2:0]  DA_DATA        = 3'h0;
  localparam logic [2:0]  DA_LBA         = 3'h3;
  localparam logic [2:0]  DA_CMD_STAT    = 3'h7;
  localparam logic [7:0]  CMD_READ       = 8'h20;
  localparam logic [7:0]  CMD_WRITE      = 8'h30;
  localparam int unsigned ST_BIT_BUSY    = 7;
  localparam int unsigned ST_BIT_LOCK    = 5;
  localparam int unsigned ST_BIT_CORR    = 2;
  localparam int unsigned ST_BIT_ERR     = 0;
  localparam logic [15:0] BUF_RESET      = 16'h0000;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PROG = 2'b01,
    ST_READ = 2'b10
  } fdbm_state_e;

  typedef struct packed {
    logic        dior_n;
    logic        diow_n;
    logic        cs0_n;
    logic        cs1_n;
    logic [2:0]  da;
    logic        csel;
    logic [15:0] dd;
  } fdbm_host_s;

  typedef struct packed {
    logic        wr;
    logic [3:0]  addr;
    logic [21:0] wdata;
  } fdbm_flash_s;

  typedef struct packed {
    logic [15:0] data;
    logic        single;
    logic        double;
  } fdbm_dec_s;

  // ------------------------------------------------------------
  // Single-correct double-detect code: Hamming 21,16 plus overall parity in bit 0
  // ------------------------------------------------------------
  function automatic logic [21:0] fdbm_ecc_encode(input logic [15:0] d);
    logic [21:0] c;
    logic [4:0]  s;
    int          j;
    c = '0;
    s = '0;
    j = 0;
    for (int p = 1; p <= 21; p++)
      if ((p & (p - 1)) != 0)
      begin
        c[p] = d[j];
        j++;
      end
    for (int p = 1; p <= 21; p++)
      if (c[p]) s = s ^ p[4:0];
    for (int k = 0; k < 5; k++)
      c[1 << k] = s[k];
    c[0] = ^c[21:1];
    return c;
  endfunction : fdbm_ecc_encode

  function automatic fdbm_dec_s fdbm_ecc_decode(input logic [21:0] cw);
    fdbm_dec_s   r;
    logic [21:0] c;
    logic [4:0]  s;
    logic        par;
    int          j;
    c   = cw;
    s   = '0;
    j   = 0;
    par = ^cw;
    for (int p = 1; p <= 21; p++)
      if (cw[p]) s = s ^ p[4:0];
    // Odd parity means one flipped bit; even parity with a syndrome means two
    r.single = par;
    r.double = !par && (s != 5'h00);
    if (par && (s != 5'h00) && (s <= 5'h15)) c[s] = ~c[s];
    r.data = '0;
    for (int p = 1; p <= 21; p++)
      if ((p & (p - 1)) != 0)
      begin
        r.data[j] = c[p];
        j++;
      end
    return r;
  endfunction : fdbm_ecc_decode

endpackage : fdbm_pkg

// [core/fdbm_core.sv]
/*
  Flash disk block manager: host strobe port, wear-spreading map, spare substitution,
  programming lock, SECDED coding and the open-drain activity/presence line.
  Assumes host pins arrive unsynchronised and the flash answers each request with a one-cycle ack.
*/
// How it works
// - Spare blocks sit above the rotating pool and only stand in for failed blocks.
// - A failed program maps a spare in its place and writes the held data there.
// - Once a program fails with every spare used, write commands are refused; reads still work.
// - Each write goes to a fresh pool block; the map points reads at the newest.
// - Stored words carry a code correcting one bit and detecting two.
// - Host pins are synchronised and sampled on the filtered read and write strobes.
// - The activity/presence line shows device activity and second device presence.
// - That line is open drain and time-shared: presence first, then activity.
`timescale 1ns/10ps
module fdbm_core #(
  parameter int unsigned P_PRESENCE_CYC = fdbm_pkg::PRESENCE_CYC
) (
  // Clock and reset
  input  wire logic                 mclk_i,
  input  wire logic                 arst_n_i,
  // Host cable
  input  wire fdbm_pkg::fdbm_host_s host_i,
  output logic [15:0]               dd_o,
  output logic                      dd_oe_o,
  output logic                      dasp_n_o,
  output logic                      dasp_n_oe_o,
  // Flash array
  output logic                      fl_req_o,
  output fdbm_pkg::fdbm_flash_s     fl_o,
  input  wire logic                 fl_ack_i,
  input  wire logic                 fl_fail_i,
  input  wire logic [21:0]          fl_rdata_i
);

  // ------------------------------------------------------------
  // Pin synchroniser and filter
  // ------------------------------------------------------------
  fdbm_pkg::fdbm_host_s s1_reg, s2_reg, s3_reg, filt_reg, filt_next, prev_reg;

  always_comb
  begin
    filt_next = filt_reg;
    // accept agreed level
    // Each pin filters on its own, so a floating data line cannot hold back a strobe
    for (int b = 0; b < $bits(fdbm_pkg::fdbm_host_s); b++)
      if (s2_reg[b] == s3_reg[b]) filt_next[b] = s3_reg[b];
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s1_reg   <= '1;
      s2_reg   <= '1;
      s3_reg   <= '1;
      filt_reg <= '1;
      prev_reg <= '1;
    end
    else
    begin
      s1_reg   <= host_i;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
      filt_reg <= filt_next;
      prev_reg <= filt_reg;
    end
  end

  logic sel0, wr_evt, rd_act;
  assign sel0   = !filt_reg.cs0_n && filt_reg.cs1_n;
  // act on the rising write strobe with the held address and data
  assign wr_evt = filt_reg.diow_n && !prev_reg.diow_n && !prev_reg.cs0_n && prev_reg.cs1_n;
  assign rd_act = !filt_reg.dior_n && sel0;

  // ------------------------------------------------------------
  // Block manager state
  // ------------------------------------------------------------
  fdbm_pkg::fdbm_state_e state_reg, state_next;
  logic [2:0]  lba_reg, lba_next;
  logic [15:0] buf_reg, buf_next;
  logic [3:0]  map_reg [fdbm_pkg::NLOG], map_next [fdbm_pkg::NLOG];
  logic [fdbm_pkg::NLOG-1:0]  mapv_reg, mapv_next;
  logic [fdbm_pkg::NPOOL-1:0] used_reg, used_next, subv_reg, subv_next;
  logic [3:0]  sub_reg [fdbm_pkg::NPOOL], sub_next [fdbm_pkg::NPOOL];
  logic [2:0]  spcnt_reg, spcnt_next;
  logic [3:0]  ptr_reg, ptr_next, tgt_reg, tgt_next, free_idx;
  logic        free_ok;
  logic        lock_reg, lock_next, err_reg, err_next, corr_reg, corr_next;
  fdbm_pkg::fdbm_dec_s dec;
  logic [3:0]  phys_tgt;

  assign dec      = fdbm_pkg::fdbm_ecc_decode(fl_rdata_i);
  assign phys_tgt = subv_reg[tgt_reg] ? sub_reg[tgt_reg] : tgt_reg;

  // first free pool block at or after the rotation pointer
  always_comb
  begin
    logic [4:0] idx;
    idx      = '0;
    free_ok  = 1'b0;
    free_idx = '0;
    for (int i = fdbm_pkg::NPOOL - 1; i >= 0; i--)
    begin
      idx = 5'(ptr_reg) + 5'(i);
      if (idx >= 5'(fdbm_pkg::NPOOL)) idx = idx - 5'(fdbm_pkg::NPOOL);
      if (!used_reg[idx[3:0]])
      begin
        free_ok  = 1'b1;
        free_idx = idx[3:0];
      end
    end
  end

  always_comb
  begin
    state_next = state_reg;
    lba_next   = lba_reg;
    buf_next   = buf_reg;
    map_next   = map_reg;
    mapv_next  = mapv_reg;
    used_next  = used_reg;
    sub_next   = sub_reg;
    subv_next  = subv_reg;
    spcnt_next = spcnt_reg;
    ptr_next   = ptr_reg;
    tgt_next   = tgt_reg;
    lock_next  = lock_reg;
    err_next   = err_reg;
    corr_next  = corr_reg;
    unique case (state_reg)
      fdbm_pkg::ST_IDLE:
      begin
        if (wr_evt && prev_reg.da == fdbm_pkg::DA_DATA) buf_next = prev_reg.dd;
        if (wr_evt && prev_reg.da == fdbm_pkg::DA_LBA) lba_next = prev_reg.dd[2:0];
        if (wr_evt && prev_reg.da == fdbm_pkg::DA_CMD_STAT)
        begin
          err_next  = 1'b0;
          corr_next = 1'b0;
          if (prev_reg.dd[7:0] == fdbm_pkg::CMD_WRITE)
          begin
            if (lock_reg || !free_ok) err_next = 1'b1;
            else
            begin
              tgt_next   = free_idx;
              state_next = fdbm_pkg::ST_PROG;
            end
          end
          else if (prev_reg.dd[7:0] == fdbm_pkg::CMD_READ)
          begin
            if (mapv_reg[lba_reg])
            begin
              tgt_next   = map_reg[lba_reg];
              state_next = fdbm_pkg::ST_READ;
            end
            else buf_next = fdbm_pkg::BUF_RESET;
          end
        end
      end
      fdbm_pkg::ST_PROG:
      begin
        if (fl_ack_i && fl_fail_i)
        begin
          // substitute a spare and program it with the held word
          if (spcnt_reg != fdbm_pkg::SPARE_ALL_USED)
          begin
            sub_next[tgt_reg]  = fdbm_pkg::SPARE_BASE + 4'(spcnt_reg);
            subv_next[tgt_reg] = 1'b1;
            spcnt_next         = spcnt_reg + 3'h1;
          end
          else
          begin
            lock_next  = 1'b1;
            err_next   = 1'b1;
            state_next = fdbm_pkg::ST_IDLE;
          end
        end
        else if (fl_ack_i)
        begin
          // retire the old copy, point the map at the new one
          if (mapv_reg[lba_reg]) used_next[map_reg[lba_reg]] = 1'b0;
          used_next[tgt_reg] = 1'b1;
          map_next[lba_reg]  = tgt_reg;
          mapv_next[lba_reg] = 1'b1;
          ptr_next   = (tgt_reg == 4'(fdbm_pkg::NPOOL - 1)) ? 4'h0 : tgt_reg + 4'h1;
          state_next = fdbm_pkg::ST_IDLE;
        end
      end
      fdbm_pkg::ST_READ:
      begin
        if (fl_ack_i)
        begin
          buf_next  = dec.data;
          corr_next = dec.single;
          // never hand back a word with two bad bits
          if (dec.double)
          begin
            buf_next = fdbm_pkg::BUF_RESET;
            err_next = 1'b1;
          end
          state_next = fdbm_pkg::ST_IDLE;
        end
      end
      default: state_next = fdbm_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state_reg <= fdbm_pkg::ST_IDLE;
      lba_reg   <= '0;
      buf_reg   <= fdbm_pkg::BUF_RESET;
      map_reg   <= '{default: 4'h0};
      mapv_reg  <= '0;
      used_reg  <= '0;
      sub_reg   <= '{default: 4'h0};
      subv_reg  <= '0;
      spcnt_reg <= '0;
      ptr_reg   <= '0;
      tgt_reg   <= '0;
      lock_reg  <= 1'b0;
      err_reg   <= 1'b0;
      corr_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      lba_reg   <= lba_next;
      buf_reg   <= buf_next;
      map_reg   <= map_next;
      mapv_reg  <= mapv_next;
      used_reg  <= used_next;
      sub_reg   <= sub_next;
      subv_reg  <= subv_next;
      spcnt_reg <= spcnt_next;
      ptr_reg   <= ptr_next;
      tgt_reg   <= tgt_next;
      lock_reg  <= lock_next;
      err_reg   <= err_next;
      corr_reg  <= corr_next;
    end
  end

  assign fl_req_o = (state_reg != fdbm_pkg::ST_IDLE);
  assign fl_o.wr    = (state_reg == fdbm_pkg::ST_PROG);
  assign fl_o.addr  = phys_tgt;
  assign fl_o.wdata = fdbm_pkg::fdbm_ecc_encode(buf_reg);

  // ------------------------------------------------------------
  // Host read data and activity/presence line
  // ------------------------------------------------------------
  logic [15:0] dd_reg, dd_next;
  logic        ddoe_reg, ddoe_next, dev1_reg, dev1_next, dasp_reg, dasp_next;
  logic [fdbm_pkg::TIMER_W-1:0] pres_reg, pres_next;
  logic        pres_on;

  assign pres_on = (pres_reg != '0);

  always_comb
  begin
    dd_next   = '0;
    ddoe_next = rd_act && (filt_reg.da == fdbm_pkg::DA_DATA || filt_reg.da == fdbm_pkg::DA_CMD_STAT);
    if (filt_reg.da == fdbm_pkg::DA_DATA) dd_next = buf_reg;
    else
    begin
      dd_next[fdbm_pkg::ST_BIT_BUSY] = (state_reg != fdbm_pkg::ST_IDLE);
      dd_next[fdbm_pkg::ST_BIT_LOCK] = lock_reg;
      dd_next[fdbm_pkg::ST_BIT_CORR] = corr_reg;
      dd_next[fdbm_pkg::ST_BIT_ERR]  = err_reg;
    end
    // Strap taken from the filtered cable select during the presence window
    dev1_next = pres_on ? !filt_reg.csel : dev1_reg;
    pres_next = pres_on ? pres_reg - 1'b1 : pres_reg;
    dasp_next = pres_on ? dev1_reg : (state_reg != fdbm_pkg::ST_IDLE);
  end

  always_ff @(posedge mclk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      dd_reg   <= '0;
      ddoe_reg <= 1'b0;
      dev1_reg <= 1'b0;
      pres_reg <= fdbm_pkg::TIMER_W'(P_PRESENCE_CYC);
      dasp_reg <= 1'b0;
    end
    else
    begin
      dd_reg   <= dd_next;
      ddoe_reg <= ddoe_next;
      dev1_reg <= dev1_next;
      pres_reg <= pres_next;
      dasp_reg <= dasp_next;
    end
  end

  assign dd_o        = dd_reg;
  assign dd_oe_o     = ddoe_reg;
  // open drain: only ever pulls low
  assign dasp_n_o    = 1'b0;
  assign dasp_n_oe_o = dasp_reg;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!arst_n_i);

  sequence prog_fail_s;
    state_reg == fdbm_pkg::ST_PROG && fl_ack_i && fl_fail_i;
  endsequence
  sequence spare_left_s;
    spcnt_reg != fdbm_pkg::SPARE_ALL_USED;
  endsequence
  sequence spare_gone_s;
    spcnt_reg == fdbm_pkg::SPARE_ALL_USED;
  endsequence

  AST_SPARE_IDLE: assert property (
    (fl_req_o && !subv_reg[tgt_reg]) |-> fl_o.addr < fdbm_pkg::SPARE_BASE)
    else $error("spare block addressed without substitution");
  AST_RELOCATE: assert property (
    (prog_fail_s and spare_left_s) |=> (fl_req_o && fl_o.wr && fl_o.addr == fdbm_pkg::SPARE_BASE + 4'($past(spcnt_reg))))
    else $error("failed block not replaced by next spare");
  AST_LOCK_SET: assert property (
    (prog_fail_s and spare_gone_s) |=> lock_reg && state_reg == fdbm_pkg::ST_IDLE)
    else $error("lock not set when spares ran out");
  AST_LOCK_HOLD: assert property (
    lock_reg && state_reg == fdbm_pkg::ST_IDLE |=> state_reg != fdbm_pkg::ST_PROG)
    else $error("programming started while locked");
  AST_NEW_PLACE: assert property (
    (state_reg == fdbm_pkg::ST_PROG && mapv_reg[lba_reg]) |-> tgt_reg != map_reg[lba_reg])
    else $error("rewrite placed on the same block");
  AST_CORRECT: assert property (
    (state_reg == fdbm_pkg::ST_READ && fl_ack_i && dec.single) |=> corr_reg && !err_reg && buf_reg == $past(dec.data))
    else $error("single-bit error not corrected");
  AST_UNC: assert property (
    (state_reg == fdbm_pkg::ST_READ && fl_ack_i && dec.double) |=> err_reg && buf_reg == fdbm_pkg::BUF_RESET)
    else $error("double-bit error not reported");
  AST_STROBE: assert property (
    wr_evt |-> !$past(filt_reg.diow_n) && $past(s2_reg.diow_n) && $past(s3_reg.diow_n))
    else $error("write taken without an agreed rising strobe");
  AST_DASP_ACT: assert property (
    (!pres_on && state_reg != fdbm_pkg::ST_IDLE) |=> dasp_n_oe_o)
    else $error("activity not shown");
  AST_DASP_MUX: assert property (
    pres_on |=> dasp_n_oe_o == $past(dev1_reg))
    else $error("presence window not honoured");

endmodule : fdbm_core

// [sim/fdbm_host_model.sv]
/*
  Host cable model: drives strobes, selects, address and data toward the core.
  Assumes the core's data outputs are merged here into the cable level it sees.
*/
`timescale 1ns/10ps
module fdbm_host_model (
  // Clock used to pace the strobes and to track the last driven level
  input  wire logic                 mclk_i,
  // Device side of the data lines
  input  wire logic [15:0]          dd_o,
  input  wire logic                 dd_oe_o,
  // Cable toward the core
  output fdbm_pkg::fdbm_host_s      host_o
);
  logic        dior_n_reg = 1'b1;
  logic        diow_n_reg = 1'b1;
  logic        cs0_n_reg  = 1'b1;
  logic [2:0]  da_reg     = 3'h0;
  logic [15:0] drv_reg    = 16'h0000;
  logic        drv_en_reg = 1'b0;
  logic [15:0] last_reg   = 16'h0000;
  logic [15:0] lvl;

  // Released lines show the inverse of the last driven level, never a stale value
  assign lvl = dd_oe_o ? dd_o : (drv_en_reg ? drv_reg : ~last_reg);
  always @(posedge mclk_i)
  begin
    if (dd_oe_o || drv_en_reg) last_reg <= lvl;
  end

  always_comb
  begin
    host_o        = '0;
    host_o.dior_n = dior_n_reg;
    host_o.diow_n = diow_n_reg;
    host_o.cs0_n  = cs0_n_reg;
    host_o.cs1_n  = 1'b1;
    host_o.da     = da_reg;
    host_o.csel   = 1'b0;
    host_o.dd     = lvl;
  end

  task automatic xfer(input logic rd, input logic [2:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge mclk_i);
    #1;
    cs0_n_reg  = 1'b0;
    da_reg     = a;
    drv_reg    = d;
    drv_en_reg = !rd;
    @(posedge mclk_i);
    #1;
    if (rd) dior_n_reg = 1'b0;
    else diow_n_reg = 1'b0;
    repeat (8) @(posedge mclk_i);
    #1;
    q = lvl;
    dior_n_reg = 1'b1;
    diow_n_reg = 1'b1;
    repeat (2) @(posedge mclk_i);
    #1;
    cs0_n_reg  = 1'b1;
    drv_en_reg = 1'b0;
    repeat (5) @(posedge mclk_i);
  endtask : xfer
endmodule : fdbm_host_model

// [sim/flash_disk_block_manager_test.sv]
/*
  Self-checking bench of the block manager: host model on the cable, flash array model inline.
  Assumes the shortened presence window of 20 cycles.
*/
`timescale 1ns/10ps
module flash_disk_block_manager_test;
  localparam int unsigned PCYC = 20;
  logic                  mclk_i   = 1'b0;
  logic                  arst_n_i = 1'b0;
  fdbm_pkg::fdbm_host_s  host_i;
  logic [15:0]           dd_o;
  logic                  dd_oe_o, dasp_n_o, dasp_n_oe_o, fl_req_o;
  fdbm_pkg::fdbm_flash_s fl_o;
  logic                  fl_ack_i = 1'b0;
  logic                  fl_fail_i = 1'b0;
  logic [21:0]           mem [0:15];
  logic [21:0]           flip = 22'h0;
  logic [3:0]            padr [0:63];
  int                    np = 0, fail_left = 0, bad_count = 0, n_checks = 0;
  logic                  saw_act = 1'b0;

  always #5 mclk_i = ~mclk_i;

  fdbm_core #(.P_PRESENCE_CYC(PCYC)) uut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .host_i(host_i),
    .dd_o(dd_o), .dd_oe_o(dd_oe_o), .dasp_n_o(dasp_n_o), .dasp_n_oe_o(dasp_n_oe_o), .fl_req_o(fl_req_o),
    .fl_o(fl_o), .fl_ack_i(fl_ack_i), .fl_fail_i(fl_fail_i), .fl_rdata_i(mem[fl_o.addr] ^ flip));
  fdbm_host_model host (.mclk_i(mclk_i), .dd_o(dd_o), .dd_oe_o(dd_oe_o), .host_o(host_i));

  // ------------------------------------------------------------
  // Flash array: one-cycle ack, program failures on demand
  // ------------------------------------------------------------
  always @(posedge mclk_i)
  begin
    fl_ack_i  <= fl_req_o && !fl_ack_i;
    fl_fail_i <= fl_req_o && !fl_ack_i && fl_o.wr && (fail_left > 0);
    if (fl_req_o && fl_ack_i && fl_o.wr)
    begin
      padr[np] <= fl_o.addr;
      np <= np + 1;
      if (fail_left > 0) fail_left <= fail_left - 1;
      else mem[fl_o.addr] <= fl_o.wdata;
    end
    if (fl_req_o && dasp_n_oe_o) saw_act <= 1'b1;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    logic [15:0] q;
    host.xfer(1'b0, a, d, q);
  endtask : wr

  task automatic wait_idle(output logic [15:0] st);
    st = 16'hffff;
    for (int i = 0; i < 40 && st[fdbm_pkg::ST_BIT_BUSY]; i++) host.xfer(1'b1, fdbm_pkg::DA_CMD_STAT, 16'h0, st);
    chk(16'(st[fdbm_pkg::ST_BIT_BUSY]), 16'h0000, "busy stuck");
  endtask : wait_idle

  task automatic op(input logic [7:0] cmd, input logic [2:0] l, input logic [15:0] d,
                    output logic [15:0] st, output logic [15:0] q);
    wr(fdbm_pkg::DA_LBA, {13'h0, l});
    if (cmd == fdbm_pkg::CMD_WRITE) wr(fdbm_pkg::DA_DATA, d);
    wr(fdbm_pkg::DA_CMD_STAT, {8'h00, cmd});
    wait_idle(st);
    host.xfer(1'b1, fdbm_pkg::DA_DATA, 16'h0, q);
  endtask : op

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_dasp;
    repeat (4) @(posedge mclk_i);
    #1;
    chk({15'h0, dasp_n_oe_o}, 16'h0000, "dasp in reset");
    chk({15'h0, dd_oe_o}, 16'h0000, "data drive in reset");
    arst_n_i = 1'b1;
    repeat (10) @(posedge mclk_i);
    #1;
    chk({15'h0, dasp_n_oe_o}, 16'h0001, "presence");
    repeat (PCYC) @(posedge mclk_i);
    #1;
    chk({15'h0, dasp_n_oe_o}, 16'h0000, "idle activity");
    chk({15'h0, dasp_n_o}, 16'h0000, "open drain value");
    $display("test dasp done");
  endtask : t_dasp

  task automatic t_rotate;
    logic [15:0] st, q;
    logic [3:0]  a1;
    op(fdbm_pkg::CMD_READ, 3'h6, 16'h0, st, q);
    chk(q, 16'h0000, "unwritten");
    op(fdbm_pkg::CMD_WRITE, 3'h1, 16'haaaa, st, q);
    a1 = padr[np-1];
    op(fdbm_pkg::CMD_WRITE, 3'h1, 16'h5555, st, q);
    chk({15'h0, a1 != padr[np-1]}, 16'h0001, "same place");
    chk({15'h0, padr[np-1] < fdbm_pkg::SPARE_BASE}, 16'h0001, "spare used");
    op(fdbm_pkg::CMD_READ, 3'h1, 16'h0, st, q);
    chk(q, 16'h5555, "newest data");
    chk({15'h0, saw_act}, 16'h0001, "activity");
    $display("test rotate done");
  endtask : t_rotate

  task automatic t_ecc;
    logic [15:0] st, q;
    flip = 22'h000020;
    op(fdbm_pkg::CMD_READ, 3'h1, 16'h0, st, q);
    chk(q, 16'h5555, "corrected");
    chk(16'(st[fdbm_pkg::ST_BIT_CORR]), 16'h0001, "corr flag");
    flip = 22'h000220;
    op(fdbm_pkg::CMD_READ, 3'h1, 16'h0, st, q);
    chk(q, 16'h0000, "double data");
    chk(16'(st[fdbm_pkg::ST_BIT_ERR]), 16'h0001, "double flag");
    flip = 22'h0;
    $display("test ecc done");
  endtask : t_ecc

  task automatic t_spare;
    logic [15:0] st, q;
    int          n0;
    fail_left = 4;
    op(fdbm_pkg::CMD_WRITE, 3'h2, 16'h1234, st, q);
    for (int k = 0; k < 4; k++) chk({12'h0, padr[np-4+k]}, 16'(12 + k), "spare order");
    op(fdbm_pkg::CMD_READ, 3'h2, 16'h0, st, q);
    chk(q, 16'h1234, "copied data");
    fail_left = 1;
    op(fdbm_pkg::CMD_WRITE, 3'h2, 16'h4321, st, q);
    chk(16'(st[fdbm_pkg::ST_BIT_LOCK]), 16'h0001, "lock");
    chk(16'(st[fdbm_pkg::ST_BIT_ERR]), 16'h0001, "exhaust err");
    n0 = np;
    op(fdbm_pkg::CMD_WRITE, 3'h3, 16'h7777, st, q);
    chk(16'(np - n0), 16'h0000, "programmed while locked");
    chk(16'(st[fdbm_pkg::ST_BIT_ERR]), 16'h0001, "refusal err");
    op(fdbm_pkg::CMD_READ, 3'h2, 16'h0, st, q);
    chk(q, 16'h1234, "locked read");
    $display("test spare done");
  endtask : t_spare

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done

  initial
  begin
    #200us;
    bad_count++;
    $display("CHECK FAILED at %0t: watchdog", $time);
    test_done;
  end

  initial
  begin
    t_dasp;
    t_rotate;
    t_ecc;
    t_spare;
    test_done;
  end
endmodule : flash_disk_block_manager_test
